// >>> hdl/mrt_pkg.sv
/*
  Package for the mode, reset and test control block: register addresses,
  field positions, reset values and timing counts.
  Assumes a 40 MHz ref_clk and an 8-bit register space addressed by a 6-bit address.
*/
package mrt_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [5:0] MRT_ADDR_SOFT_RESET = 6'h00;
  localparam logic [5:0] MRT_ADDR_CONV_LP    = 6'h07;
  localparam logic [5:0] MRT_ADDR_TEST_LOOP  = 6'h0D;
  localparam logic [5:0] MRT_ADDR_RX_BIAS    = 6'h13;
  localparam int         MRT_NUM_REGS        = 64;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MRT_BIT_SOFT_RESET  = 5;
  localparam int MRT_BIT_CONV_LP     = 4;
  localparam int MRT_BIT_ANA_LOOP    = 7;
  localparam int MRT_BIT_DIG_LOOP    = 6;
  localparam int MRT_BIT_RX_TRISTATE = 5;
  localparam int MRT_CGS_HI          = 7;
  localparam int MRT_CGS_LO          = 5;
  localparam int MRT_SGS_HI          = 4;
  localparam int MRT_SGS_LO          = 3;
  localparam int MRT_CONV_HI         = 2;
  localparam int MRT_CONV_LO         = 0;

  // ****************************************
  // Values
  // ****************************************
  localparam logic [7:0] MRT_RX_BIAS_RST    = 8'h00;
  localparam logic [2:0] MRT_CONV_LP_CODE   = 3'h3;
  localparam logic [7:0] MRT_TEST_LOOP_RST  = 8'h00;
  localparam logic [7:0] MRT_SOFT_RESET_RST = 8'h00;
  localparam logic [7:0] MRT_CONV_LP_RST    = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int MRT_CLK_PERIOD_NS  = 25;
  localparam int MRT_RST_MIN_NS     = 50;
  localparam int MRT_RST_MIN_CYCLES =
    (MRT_RST_MIN_NS + MRT_CLK_PERIOD_NS - 1) / MRT_CLK_PERIOD_NS;
  localparam int MRT_CAL_CYCLES     = 16;

endpackage

// >>> hdl/mrt_default_rom.sv
/*
  Default table for the serial-port registers, chosen by the two strap pins.
  Assumes the caller registers the straps; read data comes out of a register.
*/
`timescale 1ns/1ps
module mrt_default_rom
  import mrt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       duplex_strap,
  input  wire logic       default_select_strap,
  input  wire logic [5:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [1:0] sel;

  assign sel = {duplex_strap, default_select_strap};

  // ****************************************
  // Table per strap combination
  // ****************************************
  always_ff @(posedge ref_clk) begin
    unique case (rd_addr)
      MRT_ADDR_RX_BIAS:    rd_data <= MRT_RX_BIAS_RST;
      MRT_ADDR_TEST_LOOP:  rd_data <= MRT_TEST_LOOP_RST;
      MRT_ADDR_SOFT_RESET: rd_data <= MRT_SOFT_RESET_RST;
      MRT_ADDR_CONV_LP:    rd_data <= MRT_CONV_LP_RST;
      default:             rd_data <= {6'h00, sel};
    endcase
  end

endmodule

// >>> hdl/mrt_reg_ram.sv
/*
  Register storage for serial-port registers that this block does not decode.
  Assumes single write port and registered read.
*/
`timescale 1ns/1ps
module mrt_reg_ram
  import mrt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [5:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [MRT_NUM_REGS];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> hdl/mrt_ctrl.sv
/*
  Mode, reset and test control: strap-selected defaults, hardware and software
  reset, receive bias fields, loopback and receive three-state.
  Assumes the host drives the serial port synchronously to ref_clk as a
  write strobe with address and data, and drives the reset pin nrst.
*/
// Notes on behaviour
// - Bias register: gain, switched, converter fields
// - Bias register resets to all zeros
// - Low-power bit equals converter code 011
// - Duplex strap low half, high full
// - Defaults loaded from strap-chosen table
// - Serial port select high ignores traffic
// - Hardware or software reset restores defaults
// - Only hardware reset starts calibration
// - Resets leave filter pipeline untouched
// - Registers cleared at the first clock edge with reset low
// - Calibration starts on reset rising edge
// - Analog loopback feeds converter into transmit
// - Digital loopback copies transmit to receive in full duplex only
// - Three-state bit floats receive port
`timescale 1ns/1ps
module mrt_ctrl
  import mrt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       duplex_strap,
  input  wire logic       default_select_strap,
  input  wire logic       serial_port_select_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [9:0] conv_data,
  input  wire logic [9:0] tx_host_data,
  input  wire logic [5:0] tx_port,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            full_duplex,
  output logic      [2:0] continuous_gain_stage_bias,
  output logic      [1:0] switched_gain_stage_bias,
  output logic      [2:0] transmit_converter_bias,
  output logic      [9:0] tx_path_data,
  output logic      [5:0] rx_port_out,
  output logic      [5:0] rx_port_oe,
  output logic            cal_start,
  output logic            cal_busy
);

  // ****************************************
  // Registers and strap capture
  // ****************************************
  logic [7:0] rx_bias_q;
  logic [7:0] conv_lp_q;
  logic [7:0] test_loop_q;
  logic       soft_reset_q;
  logic       duplex_q;
  logic       defsel_q;
  logic       nrst_q;
  logic [4:0] cal_cnt_q;
  logic       rd_pend_q;
  logic [5:0] rd_addr_q;
  logic       port_wr;
  logic       any_reset;
  logic [2:0] conv_code;
  logic [7:0] ram_rdata;
  logic [7:0] rom_rdata;
  logic [7:0] local_rdata;
  logic       load_q;
  logic [5:0] load_addr_q;
  logic       load_wr_q;
  logic [5:0] load_wr_addr_q;
  logic       ram_wr;
  logic [5:0] ram_waddr;
  logic [7:0] ram_wdata;

  // Serial port is live only while its select pin is low
  assign port_wr   = reg_wr && !serial_port_select_n;
  assign any_reset = !nrst || soft_reset_q;

  // Straps caught by a clocked process; defaults follow the current levels
  always_ff @(posedge ref_clk) begin
    duplex_q <= duplex_strap;
    defsel_q <= default_select_strap;
  end

  // Reset pin history, for the release edge
  always_ff @(posedge ref_clk) begin
    nrst_q <= nrst;
  end

  // ****************************************
  // Controlled registers
  // ****************************************
  // Reset is sampled on the clock: registers clear at the first edge with nrst low
  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      rx_bias_q   <= MRT_RX_BIAS_RST;
      conv_lp_q   <= MRT_CONV_LP_RST;
      test_loop_q <= MRT_TEST_LOOP_RST;
    end else if (port_wr) begin
      unique case (reg_addr)
        MRT_ADDR_RX_BIAS:   rx_bias_q   <= reg_wdata;
        MRT_ADDR_CONV_LP:   conv_lp_q   <= reg_wdata;
        MRT_ADDR_TEST_LOOP: test_loop_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Software reset bit: one cycle of reset, then reads back zero
  always_ff @(posedge ref_clk) begin
    if (!nrst || soft_reset_q) begin
      soft_reset_q <= 1'b0;
    end else if (port_wr && reg_addr == MRT_ADDR_SOFT_RESET) begin
      soft_reset_q <= reg_wdata[MRT_BIT_SOFT_RESET];
    end
  end

  // ****************************************
  // Other registers and defaults
  // ****************************************
  // Each reset restarts a walk that copies the strap-chosen table into the
  // plain registers; host writes to plain registers are dropped while it runs
  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      load_q      <= 1'b1;
      load_addr_q <= 6'h00;
    end else if (load_q) begin
      load_addr_q <= load_addr_q + 6'h01;
      if (load_addr_q == 6'(MRT_NUM_REGS - 1)) begin
        load_q <= 1'b0;
      end
    end
  end

  // Table data arrive one cycle after the address, so the write lags by one
  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      load_wr_q      <= 1'b0;
      load_wr_addr_q <= 6'h00;
    end else begin
      load_wr_q      <= load_q;
      load_wr_addr_q <= load_addr_q;
    end
  end

  assign ram_wr    = load_wr_q || (port_wr && !load_q);
  assign ram_waddr = load_wr_q ? load_wr_addr_q : reg_addr;
  assign ram_wdata = load_wr_q ? rom_rdata : reg_wdata;

  mrt_reg_ram u_ram (
    .ref_clk (ref_clk),
    .wr_en   (ram_wr),
    .wr_addr (ram_waddr),
    .wr_data (ram_wdata),
    .rd_addr (reg_addr),
    .rd_data (ram_rdata)
  );

  mrt_default_rom u_rom (
    .ref_clk              (ref_clk),
    .duplex_strap         (duplex_q),
    .default_select_strap (defsel_q),
    .rd_addr              (load_addr_q),
    .rd_data              (rom_rdata)
  );

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 6'h00;
    end else begin
      rd_pend_q <= reg_rd && !serial_port_select_n;
      rd_addr_q <= reg_addr;
    end
  end

  always_comb begin
    unique case (rd_addr_q)
      MRT_ADDR_RX_BIAS:    local_rdata = rx_bias_q;
      MRT_ADDR_CONV_LP:    local_rdata = conv_lp_q;
      MRT_ADDR_TEST_LOOP:  local_rdata = test_loop_q;
      MRT_ADDR_SOFT_RESET: local_rdata = {2'h0, soft_reset_q, 5'h00};
      default:             local_rdata = ram_rdata ^ 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_q;
      reg_rdata  <= rd_pend_q ? local_rdata : 8'h00;
    end
  end

  // ****************************************
  // Bias outputs
  // ****************************************
  assign conv_code = conv_lp_q[MRT_BIT_CONV_LP] ? MRT_CONV_LP_CODE
                                                : rx_bias_q[MRT_CONV_HI:MRT_CONV_LO];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      continuous_gain_stage_bias <= 3'h0;
      switched_gain_stage_bias   <= 2'h0;
      transmit_converter_bias    <= 3'h0;
      full_duplex                <= 1'b0;
    end else begin
      continuous_gain_stage_bias <= rx_bias_q[MRT_CGS_HI:MRT_CGS_LO];
      switched_gain_stage_bias   <= rx_bias_q[MRT_SGS_HI:MRT_SGS_LO];
      transmit_converter_bias    <= conv_code;
      full_duplex                <= duplex_q;
    end
  end

  // ****************************************
  // Calibration start
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cal_start <= 1'b0;
      cal_cnt_q <= 5'h00;
      cal_busy  <= 1'b0;
    end else begin
      cal_start <= !nrst_q;
      if (!nrst_q) begin
        cal_cnt_q <= 5'(MRT_CAL_CYCLES);
        cal_busy  <= 1'b1;
      end else if (cal_cnt_q != 5'h00) begin
        cal_cnt_q <= cal_cnt_q - 5'h01;
        cal_busy  <= (cal_cnt_q != 5'h01);
      end
    end
  end

  // ****************************************
  // Loopback and receive port
  // ****************************************
  // Data path is not reset so the filter pipeline keeps its contents
  always_ff @(posedge ref_clk) begin
    tx_path_data <= test_loop_q[MRT_BIT_ANA_LOOP] ? conv_data : tx_host_data;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_port_out <= 6'h00;
      rx_port_oe  <= 6'h00;
    end else begin
      rx_port_out <= (test_loop_q[MRT_BIT_DIG_LOOP] && duplex_q) ? tx_port
                                                                 : conv_data[9:4];
      rx_port_oe  <= test_loop_q[MRT_BIT_RX_TRISTATE] ? 6'h00 : 6'h3F;
    end
  end

endmodule

// >>> dv/mrt_ctrl_sva.sv
/* Port checker for mrt_ctrl.
   Assumes one ref_clk domain and nrst sync low; bound at the foot. */
`timescale 1ns/1ps
module mrt_ctrl_sva
  import mrt_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       duplex_strap,
  input wire logic       serial_port_select_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rvalid,
  input wire logic       full_duplex,
  input wire logic [2:0] continuous_gain_stage_bias,
  input wire logic [2:0] transmit_converter_bias,
  input wire logic       cal_start
);
  // ****
  // Relations
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wr_ok;
  assign wr_ok = reg_wr && !serial_port_select_n;
  a_bias_write: assert property (
    wr_ok && reg_addr == MRT_ADDR_RX_BIAS |->
    ##2 continuous_gain_stage_bias == $past(reg_wdata[7:5], 2)) else $error("bias field wrong");
  a_conv_low_power: assert property (
    wr_ok && reg_addr == MRT_ADDR_CONV_LP && reg_wdata[4] |->
    ##2 transmit_converter_bias == MRT_CONV_LP_CODE) else $error("low power code wrong");
  a_select_ignores: assert property (
    reg_rd && serial_port_select_n |-> ##2 !reg_rvalid) else $error("deselected read answered");
  a_soft_clears: assert property (
    wr_ok && reg_addr == MRT_ADDR_SOFT_RESET && reg_wdata[5] |->
    ##3 continuous_gain_stage_bias == 3'h0 && transmit_converter_bias == 3'h0)
    else $error("soft reset kept bias");
  a_soft_no_cal: assert property (
    wr_ok && reg_addr == MRT_ADDR_SOFT_RESET && reg_wdata[5] |-> ##1 !cal_start [*4])
    else $error("soft reset started calibration");
  a_cal_on_rise: assert property (
    $rose(nrst) |-> ##[1:2] cal_start) else $error("no calibration after release");
  a_cal_single: assert property (
    cal_start |=> !cal_start) else $error("calibration start too long");
  a_duplex_strap: assert property (
    $past(nrst) |-> full_duplex == $past(duplex_strap, 2)) else $error("duplex mode wrong");
endmodule

bind mrt_ctrl mrt_ctrl_sva mrt_ctrl_sva_i (.ref_clk, .nrst, .duplex_strap,
  .serial_port_select_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid,
  .full_duplex, .continuous_gain_stage_bias, .transmit_converter_bias, .cal_start);

// >>> dv/mrt_host_model.sv
/* Host model: serial port accesses and the reset pin.
   Assumes the bench calls its tasks; all changes follow ref_clk rises. */
`timescale 1ns/1ps
module mrt_host_model (
  input  wire logic       ref_clk,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  output logic            nrst,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // ****
  // Reset and access cycles
  // ****
  initial {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Held low from power-up and for n edges after the next ref_clk rise
  task automatic hw_reset(input int n);
    @(posedge ref_clk) nrst <= 1'h0;
    repeat (n) @(posedge ref_clk);
    nrst <= 1'h1;
  endtask
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    @(posedge ref_clk);
    reg_wr    <= w;
    reg_rd    <= ~w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'h0;
    reg_rd    <= 1'h0;
    // Released lines show the inverse
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    ok = w;
    q  = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge ref_clk);
      if (reg_rvalid === 1'h1) begin
        ok = 1'h1;
        q  = reg_rdata;
      end
    end
  endtask
endmodule

// >>> dv/testbench.sv
/* Self-checking bench for mrt_ctrl.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module testbench
  import mrt_pkg::*;
;
  typedef struct packed {logic [7:0] d; logic lp; logic [2:0] c;} mrt_row_t;
  localparam mrt_row_t ROWS [4] = '{'{8'hE5, 1'h0, 3'h5}, '{8'h1A, 1'h1, 3'h3},
                                    '{8'hFF, 1'h1, 3'h3}, '{8'h5E, 1'h0, 3'h6}};
  logic       ref_clk = 1'h0, duplex = 1'h1, defsel = 1'h0, sel_n = 1'h0;
  logic [9:0] conv = 10'h2A5, txh = 10'h15A, txd;
  logic [5:0] txp = 6'h2C, addr, oe, rxo;
  logic       nrst, wr, rd, rvalid, fdx, cstart, cbusy, ok;
  logic [7:0] wdata, rdata, q;
  logic [2:0] cgs, tcb;
  logic [1:0] sgs;
  int         bad_count = 0, n_compared = 0, n_cal = 0, k;
  mrt_host_model host_i (.ref_clk(ref_clk), .reg_rvalid(rvalid), .reg_rdata(rdata),
    .nrst(nrst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
  mrt_ctrl mrt_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .duplex_strap(duplex),
    .default_select_strap(defsel), .serial_port_select_n(sel_n), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .conv_data(conv),
    .tx_host_data(txh), .tx_port(txp), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .full_duplex(fdx), .continuous_gain_stage_bias(cgs), .switched_gain_stage_bias(sgs),
    .transmit_converter_bias(tcb), .tx_path_data(txd), .rx_port_out(rxo),
    .rx_port_oe(oe), .cal_start(cstart), .cal_busy(cbusy));
  // ****
  // Helpers
  // ****
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (cstart === 1'h1) n_cal++;
  task automatic chk(input string s, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic w8(input logic [5:0] a, input logic [7:0] d);
    host_i.access(1'h1, a, d, q, ok);
    cyc(2);
  endtask
  // A read that times out shows as ok low
  task automatic rchk(input string s, input logic [5:0] a, input logic [8:0] exp);
    host_i.access(1'h0, a, 8'h00, q, ok);
    chk(s, {1'h0, ok, q}, {1'h0, exp});
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    host_i.hw_reset(5);
    cyc(4);
    chk("cal", n_cal, 1);
    chk("busy", cbusy, 1);
    chk("fdx", fdx, 1);
    rchk("bias", MRT_ADDR_RX_BIAS, 9'h100);
    rchk("test", MRT_ADDR_TEST_LOOP, 9'h100);
    rchk("lp", MRT_ADDR_CONV_LP, 9'h100);
    foreach (ROWS[i]) begin
      w8(MRT_ADDR_CONV_LP, {3'h0, ROWS[i].lp, 4'h0});
      w8(MRT_ADDR_RX_BIAS, ROWS[i].d);
      chk("cgs", cgs, ROWS[i].d[7:5]);
      chk("sgs", sgs, ROWS[i].d[4:3]);
      chk("conv", tcb, ROWS[i].c);
      rchk("rb", MRT_ADDR_RX_BIAS, {1'h1, ROWS[i].d});
    end
    w8(MRT_ADDR_TEST_LOOP, 8'h80);
    chk("aloop", txd, conv);
    chk("rx", rxo, conv[9:4]);
    w8(MRT_ADDR_TEST_LOOP, 8'h40);
    chk("dloop", rxo, txp);
    chk("txh", txd, txh);
    chk("oe", oe, 6'h3F);
    w8(MRT_ADDR_TEST_LOOP, 8'h20);
    chk("tri", oe, 6'h00);
    @(posedge ref_clk) sel_n <= 1'h1;
    w8(MRT_ADDR_RX_BIAS, 8'hFF);
    chk("sel", cgs, 3'h2);
    rchk("selrd", MRT_ADDR_RX_BIAS, 9'h000);
    @(posedge ref_clk) sel_n <= 1'h0;
    rchk("def", 6'h01, 9'h102);
    w8(6'h01, 8'hA5);
    rchk("plain", 6'h01, 9'h1A5);
    k = n_cal;
    w8(MRT_ADDR_SOFT_RESET, 8'h20);
    cyc(1);
    chk("scgs", cgs, 0);
    chk("sconv", tcb, 0);
    chk("soe", oe, 6'h3F);
    chk("scal", n_cal, k);
    rchk("sbit", MRT_ADDR_SOFT_RESET, 9'h100);
    cyc(66);
    rchk("sdef", 6'h01, 9'h102);
    w8(MRT_ADDR_RX_BIAS, 8'hE5);
    @(posedge ref_clk) begin
      duplex <= 1'h0;
      defsel <= 1'h1;
    end
    fork
      host_i.hw_reset(4);
      begin
        cyc(3);
        chk("hcgs", cgs, 0);
        chk("hoe", oe, 6'h00);
        chk("hcal", n_cal, k);
        chk("htx", txd, txh);
      end
    join
    cyc(4);
    chk("hcal2", n_cal, k + 1);
    chk("hfdx", fdx, 0);
    rchk("hbias", MRT_ADDR_RX_BIAS, 9'h100);
    w8(MRT_ADDR_TEST_LOOP, 8'h40);
    chk("half", rxo, conv[9:4]);
    cyc(60);
    rchk("hdef", 6'h01, 9'h101);
    end_sim();
  end
endmodule
